// file: verilog/dtc_defines.svh
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// Clock rate and the quantum of every dead time.
`define DTC_CLK_MHZ 40
`define DTC_CLK_PERIOD_NS 25

// Dead time limits in nanoseconds and the derived cycle counts.
`define DTC_DEAD_MIN_NS 75
`define DTC_DEAD_MAX_NS 375
`define DTC_DEAD_MIN_CYC ((`DTC_DEAD_MIN_NS + `DTC_CLK_PERIOD_NS - 1) / `DTC_CLK_PERIOD_NS)
`define DTC_DEAD_MAX_CYC (`DTC_DEAD_MAX_NS / `DTC_CLK_PERIOD_NS)

// Interval to dead time divisors, expressed as right shifts.
`define DTC_RECT_SHIFT 6
`define DTC_PRIM_SHIFT 5

// Shortest switching half period in pulse-width operation, in nanoseconds.
`define DTC_PWM_MIN_HALF_NS 1840
`define DTC_PWM_MIN_HALF_CYC \
   ((`DTC_PWM_MIN_HALF_NS + `DTC_CLK_PERIOD_NS - 1) / `DTC_CLK_PERIOD_NS)

// Widths and reset values.
`define DTC_CNT_W 16
`define DTC_DEAD_W 4
`define DTC_HALF_W 8
`define DTC_CNT_RESET 16'h0000
`define DTC_DEAD_RESET 4'h3

`endif

// file: verilog/dtc_pkg.sv
`default_nettype none

package dtc_pkg;

   // Calibration sequence of the programming node.
   typedef enum logic [2:0] {
      DTC_WAIT_BIAS,
      DTC_PRECHARGE,
      DTC_PREDISCHARGE,
      DTC_MEASURE_RISE,
      DTC_MEASURE_FALL,
      DTC_DONE
   } dtc_state_t;

endpackage

`default_nettype wire

// file: verilog/dtc_gate_pair.sv
`include "dtc_defines.svh"
`default_nettype none

module dtc_gate_pair (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic phase,
   input wire logic [`DTC_DEAD_W-1:0] dead_cycles,
   output logic gate_a,
   output logic gate_b
);

   logic gate_a_reg, gate_a_next;
   logic gate_b_reg, gate_b_next;
   logic phase_reg, phase_next;
   logic [`DTC_DEAD_W-1:0] gap_reg, gap_next;

   // A phase change drops both gates and waits out the dead time before the
   // new side turns on, so the two gates never conduct together.
   always_comb begin
      phase_next = phase;
      gap_next = gap_reg;
      gate_a_next = 1'b0;
      gate_b_next = 1'b0;
      if (!enable) begin
         gap_next = dead_cycles;
      end else if (phase != phase_reg) begin
         gap_next = dead_cycles - 4'h1; // This cycle is the first dead cycle.
      end else if (gap_reg != 4'h0) begin
         gap_next = gap_reg - 4'h1;
      end else begin
         gate_a_next = phase_reg;
         gate_b_next = !phase_reg;
      end
   end

   // State registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate_a_reg <= 1'b0;
         gate_b_reg <= 1'b0;
         phase_reg <= 1'b0;
         gap_reg <= `DTC_DEAD_RESET;
      end else begin
         gate_a_reg <= gate_a_next;
         gate_b_reg <= gate_b_next;
         phase_reg <= phase_next;
         gap_reg <= gap_next;
      end
   end

   assign gate_a = gate_a_reg;
   assign gate_b = gate_b_reg;

   // Assertions on the gate pair.
   no_overlap_a: assert property (@(posedge clk) disable iff (rst)
      !(gate_a_reg && gate_b_reg))
      else $error("both gates of a pair are on");
   least_gap_a: assert property (@(posedge clk) disable iff (rst)
      $fell(gate_a_reg) |-> !gate_b_reg [*3])
      else $error("dead gap shorter than the least dead time");

endmodule

`default_nettype wire

// file: verilog/dtc_calibrator.sv
`include "dtc_defines.svh"
`default_nettype none

module dtc_calibrator (
   input wire logic clk,
   input wire logic rst,
   input wire logic bias_supply_pin,
   input wire logic node_above_1v,
   input wire logic node_above_1v4,
   input wire logic node_above_3v,
   input wire logic node_held_low,
   input wire logic feedback_below_threshold,
   input wire logic switch_phase,
   output logic discharge_current_sink,
   output logic pwm_mode,
   output logic calibration_done,
   output logic primary_gate_drive_a,
   output logic primary_gate_drive_b,
   output logic rectifier_gate_drive_a,
   output logic rectifier_gate_drive_b
);

   // Divides a count by a power of two and keeps it inside the dead time range.
   function automatic logic [`DTC_DEAD_W-1:0] clamp_dead(input logic [`DTC_CNT_W-1:0] count,
                                                       input int shift);
      logic [`DTC_CNT_W-1:0] q;
      q = count >> shift;
      if (q < `DTC_CNT_W'(`DTC_DEAD_MIN_CYC)) begin
         return `DTC_DEAD_W'(`DTC_DEAD_MIN_CYC);
      end else if (q > `DTC_CNT_W'(`DTC_DEAD_MAX_CYC)) begin
         return `DTC_DEAD_W'(`DTC_DEAD_MAX_CYC);
      end
      return q[`DTC_DEAD_W-1:0];
   endfunction

   dtc_pkg::dtc_state_t state_reg, state_next;
   logic sink_reg, sink_next;
   logic [`DTC_CNT_W-1:0] rise_cnt_reg, rise_cnt_next;
   logic [`DTC_CNT_W-1:0] fall_cnt_reg, fall_cnt_next;
   logic [`DTC_DEAD_W-1:0] rect_dead_reg, rect_dead_next;
   logic [`DTC_DEAD_W-1:0] prim_dead_reg, prim_dead_next;
   logic pwm_reg, pwm_next;
   logic phase_reg, phase_next;
   logic [`DTC_HALF_W-1:0] half_reg, half_next;
   logic done_reg;
   logic run_primary, run_rectifier;

   // Calibration sequence. Counts saturate so a missing comparator edge
   // cannot wrap into a short dead time; the clamp then gives the maximum.
   always_comb begin
      state_next = state_reg;
      sink_next = sink_reg;
      rise_cnt_next = rise_cnt_reg;
      fall_cnt_next = fall_cnt_reg;
      rect_dead_next = rect_dead_reg;
      prim_dead_next = prim_dead_reg;
      case (state_reg)
         dtc_pkg::DTC_WAIT_BIAS: begin
            sink_next = 1'b0;
            if (bias_supply_pin) begin
               state_next = dtc_pkg::DTC_PRECHARGE;
            end
         end
         dtc_pkg::DTC_PRECHARGE: begin
            if (node_above_1v4) begin
               sink_next = 1'b1;
               state_next = dtc_pkg::DTC_PREDISCHARGE;
            end
         end
         dtc_pkg::DTC_PREDISCHARGE: begin
            if (!node_above_1v) begin
               sink_next = 1'b0;
               rise_cnt_next = `DTC_CNT_RESET;
               state_next = dtc_pkg::DTC_MEASURE_RISE;
            end
         end
         dtc_pkg::DTC_MEASURE_RISE: begin
            if (node_above_3v) begin
               sink_next = 1'b1;
               fall_cnt_next = `DTC_CNT_RESET;
               rect_dead_next = clamp_dead(rise_cnt_reg, `DTC_RECT_SHIFT);
               state_next = dtc_pkg::DTC_MEASURE_FALL;
            end else if (rise_cnt_reg != {`DTC_CNT_W{1'b1}}) begin
               rise_cnt_next = rise_cnt_reg + `DTC_CNT_W'(1);
            end
         end
         dtc_pkg::DTC_MEASURE_FALL: begin
            if (!node_above_1v) begin
               sink_next = 1'b0;
               prim_dead_next = clamp_dead(fall_cnt_reg, `DTC_PRIM_SHIFT);
               state_next = dtc_pkg::DTC_DONE;
            end else if (fall_cnt_reg != {`DTC_CNT_W{1'b1}}) begin
               fall_cnt_next = fall_cnt_reg + `DTC_CNT_W'(1);
            end
         end
         dtc_pkg::DTC_DONE: begin
            sink_next = 1'b0; // Results stay until reset.
         end
         default: begin
            state_next = dtc_pkg::DTC_WAIT_BIAS;
            sink_next = 1'b0;
         end
      endcase
   end

   // Calibration registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= dtc_pkg::DTC_WAIT_BIAS;
         sink_reg <= 1'b0;
         rise_cnt_reg <= `DTC_CNT_RESET;
         fall_cnt_reg <= `DTC_CNT_RESET;
         rect_dead_reg <= `DTC_DEAD_RESET;
         prim_dead_reg <= `DTC_DEAD_RESET;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sink_reg <= sink_next;
         rise_cnt_reg <= rise_cnt_next;
         fall_cnt_reg <= fall_cnt_next;
         rect_dead_reg <= rect_dead_next;
         prim_dead_reg <= prim_dead_next;
         done_reg <= (state_next == dtc_pkg::DTC_DONE);
      end
   end

   // Mode and phase. The feedback clamp itself is analog; here the mode flag
   // records it. In pulse-width operation a phase change is held back until
   // the shortest half period has run, which caps the switching frequency.
   always_comb begin
      pwm_next = feedback_below_threshold;
      phase_next = phase_reg;
      half_next = half_reg;
      if (half_reg != {`DTC_HALF_W{1'b1}}) begin
         half_next = half_reg + `DTC_HALF_W'(1);
      end
      if (switch_phase != phase_reg) begin
         if (!pwm_reg || half_reg >= `DTC_HALF_W'(`DTC_PWM_MIN_HALF_CYC)) begin
            phase_next = switch_phase;
            half_next = `DTC_HALF_W'(0);
         end
      end
   end

   // Mode and phase registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwm_reg <= 1'b0;
         phase_reg <= 1'b0;
         half_reg <= `DTC_HALF_W'(0);
      end else begin
         pwm_reg <= pwm_next;
         phase_reg <= phase_next;
         half_reg <= half_next;
      end
   end

   // Switching needs a finished calibration and a node that is not held low.
   assign run_primary = done_reg && !node_held_low;
   assign run_rectifier = run_primary && !pwm_reg;

   dtc_gate_pair primary_pair (
      .clk(clk),
      .rst(rst),
      .enable(run_primary),
      .phase(phase_reg),
      .dead_cycles(prim_dead_reg),
      .gate_a(primary_gate_drive_a),
      .gate_b(primary_gate_drive_b)
   );

   dtc_gate_pair rectifier_pair (
      .clk(clk),
      .rst(rst),
      .enable(run_rectifier),
      .phase(phase_reg),
      .dead_cycles(rect_dead_reg),
      .gate_a(rectifier_gate_drive_a),
      .gate_b(rectifier_gate_drive_b)
   );

   assign discharge_current_sink = sink_reg;
   assign pwm_mode = pwm_reg;
   assign calibration_done = done_reg;

   // Steps of the calibration sequence.
   sequence at_first_peak_s;
      state_reg == dtc_pkg::DTC_PRECHARGE && node_above_1v4;
   endsequence
   sequence fall_ends_s;
      state_reg == dtc_pkg::DTC_MEASURE_FALL && !node_above_1v;
   endsequence

   first_sink_a: assert property (@(posedge clk) disable iff (rst)
      at_first_peak_s |=> sink_reg && state_reg == dtc_pkg::DTC_PREDISCHARGE)
      else $error("sink not on after the first peak");
   rise_sink_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == dtc_pkg::DTC_MEASURE_RISE |-> !sink_reg)
      else $error("sink on while timing the rise");
   fall_sink_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == dtc_pkg::DTC_MEASURE_FALL |-> sink_reg)
      else $error("sink off while timing the fall");
   release_node_a: assert property (@(posedge clk) disable iff (rst)
      fall_ends_s |=> !sink_reg ##1 (!sink_reg && done_reg))
      else $error("sink not released after calibration");
   count_step_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == dtc_pkg::DTC_MEASURE_RISE && !node_above_3v && rise_cnt_reg < 16'h00ff
      |=> rise_cnt_reg == $past(rise_cnt_reg) + 16'h0001)
      else $error("rise count did not advance by one");
   rect_value_a: assert property (@(posedge clk) disable iff (rst)
      state_reg == dtc_pkg::DTC_MEASURE_RISE && node_above_3v
      |=> rect_dead_reg == clamp_dead($past(rise_cnt_reg), 6))
      else $error("rectifier dead time wrong");
   dead_range_a: assert property (@(posedge clk) disable iff (rst)
      done_reg |-> rect_dead_reg >= 4'h3 && rect_dead_reg <= 4'hf && prim_dead_reg >= 4'h3)
      else $error("dead time out of range");
   rect_off_pwm_a: assert property (@(posedge clk) disable iff (rst)
      feedback_below_threshold |-> ##2 !rectifier_gate_drive_a && !rectifier_gate_drive_b)
      else $error("rectifier gate on in pulse-width operation");
   shutdown_a: assert property (@(posedge clk) disable iff (rst)
      node_held_low |=> !primary_gate_drive_a && !primary_gate_drive_b
      && !rectifier_gate_drive_a && !rectifier_gate_drive_b)
      else $error("switching while node held low");
   freq_cap_a: assert property (@(posedge clk) disable iff (rst)
      pwm_reg && switch_phase != phase_reg && half_reg < 8'd74 |=> $stable(phase_reg))
      else $error("half period too short in pulse-width operation");

endmodule

`default_nettype wire

// file: testbench/dtc_node_model.sv
`default_nettype none

module dtc_node_model (
   input wire logic clk,
   input wire logic sink,
   input wire logic pull_low,
   input wire integer rise_step,
   input wire integer fall_step,
   output logic node_above_1v,
   output logic node_above_1v4,
   output logic node_above_3v,
   output logic node_held_low
);
   timeunit 1ns;
   timeprecision 1ps;

   int node_uv = 0;

   // The node ramps one fixed step a cycle and stops near the 5 V rail, like a constant-current charge.
   always @(posedge clk) begin
      if (pull_low) begin
         node_uv <= 0;
      end else if (sink) begin
         node_uv <= (node_uv > fall_step) ? node_uv - fall_step : 0;
      end else if (node_uv < 5000000) begin
         node_uv <= node_uv + rise_step;
      end
   end

   // Comparators see the ramp directly; a grounded node reads as a shutdown request.
   assign node_above_1v = node_uv > 1000000;
   assign node_above_1v4 = node_uv >= 1400000;
   assign node_above_3v = node_uv >= 3000000;
   assign node_held_low = pull_low;
endmodule

`default_nettype wire

// file: testbench/test_dead_time_calibrator.sv
`default_nettype none

module test_dead_time_calibrator;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic ph; logic fb; logic [4:0] exp;} dtc_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bias = 1'b0;
   logic fb = 1'b0;
   logic phase = 1'b0;
   logic pull = 1'b0;
   int rstep = 2976;
   int fstep = 7353;
   logic a1, a14, a3, held, sink, pwm, done, pa, pb, ra, rb;
   int err_total = 0;
   int n_compared = 0;
   int cycles = 0;
   dtc_row_t rows [5] = '{'{1'b1, 1'b0, 5'h0a}, '{1'b0, 1'b0, 5'h05},
      '{1'b1, 1'b1, 5'h18}, '{1'b0, 1'b1, 5'h14}, '{1'b1, 1'b0, 5'h0a}};

   // A 25 ns clock.
   always #12.5 clk = ~clk;

   dtc_calibrator i_dtc_calibrator (.clk(clk), .rst(rst), .bias_supply_pin(bias),
      .node_above_1v(a1), .node_above_1v4(a14), .node_above_3v(a3),
      .node_held_low(held), .feedback_below_threshold(fb), .switch_phase(phase),
      .discharge_current_sink(sink), .pwm_mode(pwm), .calibration_done(done),
      .primary_gate_drive_a(pa), .primary_gate_drive_b(pb),
      .rectifier_gate_drive_a(ra), .rectifier_gate_drive_b(rb));

   dtc_node_model i_dtc_node_model (.clk(clk), .sink(sink), .pull_low(pull),
      .rise_step(rstep), .fall_step(fstep), .node_above_1v(a1), .node_above_1v4(a14),
      .node_above_3v(a3), .node_held_low(held));

   task automatic complete_run();
      if (err_total == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Runs one calibration, then times both gaps on a single phase change.
   task automatic calibrate(input int rect_d, input int prim_d);
      int i;
      int np;
      int nr;
      np = 0;
      nr = 0;
      repeat (20) @(posedge clk);
      #1;
      chk(16'({sink, done}), 16'h0000);
      @(posedge clk);
      bias <= 1'b1;
      // Look just after each edge, so a register that changes on it is seen in that same cycle.
      for (i = 0; i < 5000 && sink !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(16'(a14), 16'h0001);
      for (i = 0; i < 5000 && done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(16'({done, sink}), 16'h0002);
      repeat (30) @(posedge clk);
      phase <= ~phase;
      repeat (60) begin
         @(posedge clk);
         #1;
         if (pa === 1'b0 && pb === 1'b0) np++;
         if (ra === 1'b0 && rb === 1'b0) nr++;
      end
      chk(16'(np), 16'(prim_d));
      chk(16'(nr), 16'(rect_d));
   endtask

   // A hang is cut short well beyond two calibrations and the table.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      #1;
      chk(16'({sink, pwm, done, pa, pb, ra, rb}), 16'h0000);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      calibrate(10, 8);
      // Steady gate levels for each phase and feedback setting.
      foreach (rows[k]) begin
         @(posedge clk);
         phase <= rows[k].ph;
         fb <= rows[k].fb;
         repeat (100) @(posedge clk);
         #1;
         chk(16'({pwm, pa, pb, ra, rb}), 16'(rows[k].exp));
      end
      // Grounding the node stops every gate for as long as it is held.
      @(posedge clk);
      pull <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(16'({pa, pb, ra, rb}), 16'h0000);
      repeat (50) @(posedge clk);
      #1;
      chk(16'({pa, pb, ra, rb}), 16'h0000);
      @(posedge clk);
      pull <= 1'b0;
      repeat (100) @(posedge clk);
      #1;
      chk(16'({pa, pb, ra, rb}), 16'h000a);
      // In pulse-width operation a quick second phase change waits for the shortest half period.
      @(posedge clk);
      fb <= 1'b1;
      repeat (100) @(posedge clk);
      phase <= 1'b0;
      repeat (10) @(posedge clk);
      phase <= 1'b1;
      repeat (66) @(posedge clk);
      #1;
      chk(16'({pa, pb}), 16'h0001);
      repeat (9) @(posedge clk);
      #1;
      chk(16'({pa, pb}), 16'h0002);
      @(posedge clk);
      fb <= 1'b0;
      // A fast rise and a slow fall drive both dead times into their limits.
      @(posedge clk);
      rst <= 1'b1;
      bias <= 1'b0;
      rstep <= 20000;
      fstep <= 3333;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      calibrate(3, 15);
      complete_run();
   end
endmodule

`default_nettype wire
